// File: pkg/dtc_pkg.sv
package dtc_pkg;

    // Register offsets on the plain register port
    localparam logic [7:0] OFS_A_VALUE   = 8'h00;
    localparam logic [7:0] OFS_A_CONTROL = 8'h01;
    localparam logic [7:0] OFS_B_LOW     = 8'h02;
    localparam logic [7:0] OFS_B_HIGH    = 8'h03;
    localparam logic [7:0] OFS_B_CONTROL = 8'h04;
    localparam logic [7:0] OFS_INT_CTRL  = 8'h05;

    // Control register field positions
    localparam int MODE_HI  = 7;
    localparam int MODE_LO  = 6;
    localparam int RUN_BIT  = 4;
    localparam int EDGE_BIT = 3;

    // Mode pair patterns; the fourth pattern (2'h0) stops counting
    localparam logic [1:0] MODE_TIMER = 2'h2;
    localparam logic [1:0] MODE_EVENT = 2'h1;
    localparam logic [1:0] MODE_PWM   = 2'h3;

    // Interrupt control register field positions
    localparam int IEN_A  = 0;
    localparam int IEN_B  = 1;
    localparam int IFLG_A = 4;
    localparam int IFLG_B = 5;

    // Internal count clock is the system clock divided by four
    localparam logic [1:0] PRESCALE_LAST = 2'h3;

    // Full counts at which the counters overflow
    localparam logic [7:0]  A_FULL = 8'hff;
    localparam logic [15:0] B_FULL = 16'hffff;

    // Values after reset
    localparam logic [7:0]  A_RESET    = 8'h00;
    localparam logic [15:0] B_RESET    = 16'h0000;
    localparam logic [1:0]  MODE_RESET = 2'h0;
    localparam logic [7:0]  RDATA_ZERO = 8'h00;

    // One register port request
    typedef struct packed {
        logic [7:0] addr;   // Register offset
        logic [7:0] wdata;  // Write data
        logic       wr;     // Write strobe
        logic       rd;     // Read strobe
    } dtc_bus_req_t;

    // Pulse width measurement sequence
    typedef enum logic [1:0] {PWM_IDLE, PWM_WAIT, PWM_MEASURE} dtc_pwm_state_t;

    // One count pulse for a counter in the present cycle
    function automatic logic dtc_count_pulse(input logic [1:0] mode, input logic run,
                                             input logic tick, input logic rise,
                                             input logic fall, input logic edge_sel,
                                             input logic measuring, input logic pd);
        dtc_count_pulse = 1'b0;
        if (mode == MODE_TIMER) begin
            dtc_count_pulse = run & tick & ~pd;
        end else if (mode == MODE_EVENT) begin
            dtc_count_pulse = run & (edge_sel ? fall : rise);
        end else if (mode == MODE_PWM) begin
            dtc_count_pulse = measuring & tick & ~pd;
        end
    endfunction : dtc_count_pulse

    // Next pulse width state; edge select low starts on a falling edge
    function automatic dtc_pwm_state_t dtc_pwm_next(input dtc_pwm_state_t st,
                                                    input logic [1:0] mode, input logic run,
                                                    input logic rise, input logic fall,
                                                    input logic edge_sel);
        dtc_pwm_next = st;
        if (!run || mode != MODE_PWM) begin
            dtc_pwm_next = PWM_IDLE;
        end else begin
            unique case (st)
                PWM_IDLE:    dtc_pwm_next = PWM_WAIT;
                PWM_WAIT:    dtc_pwm_next = (edge_sel ? rise : fall) ? PWM_MEASURE : PWM_WAIT;
                PWM_MEASURE: dtc_pwm_next = (edge_sel ? fall : rise) ? PWM_IDLE : PWM_MEASURE;
            endcase
        end
    endfunction : dtc_pwm_next

endpackage : dtc_pkg

// File: design/dtc_pin_edge.sv
`timescale 1ns/100ps

module dtc_pin_edge (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rstn_sync,
    // Asynchronous pin
    input  wire logic pin,
    // Filtered edges, one cycle each
    output logic      rise,
    output logic      fall
);

    logic sync1_r;  // First stage, read only by the second
    logic sync2_r;  // Second stage
    logic sync3_r;  // Third stage
    logic level_r;  // Accepted pin level

    // Three stage synchroniser
    always_ff @(posedge clock or negedge rstn_sync) begin
        if (!rstn_sync) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
        end else begin
            sync1_r <= pin;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // A change counts once the second and third stages agree
    always_ff @(posedge clock or negedge rstn_sync) begin
        if (!rstn_sync) begin
            level_r <= 1'b0;
            rise    <= 1'b0;
            fall    <= 1'b0;
        end else begin
            rise <= (sync2_r == sync3_r) & sync3_r & ~level_r;
            fall <= (sync2_r == sync3_r) & ~sync3_r & level_r;
            if (sync2_r == sync3_r) begin
                level_r <= sync3_r;
            end
        end
    end

endmodule : dtc_pin_edge

// File: design/dtc_top.sv
`timescale 1ns/100ps

module dtc_top (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  rstn,
    // Register port
    input  wire dtc_pkg::dtc_bus_req_t bus_req,
    output logic [7:0]                 bus_rdata,
    // External event or pulse pins
    input  wire logic                  counter_a_value_or_input_pin,
    input  wire logic                  counter_b_input_pin,
    // Power-down state of the device
    input  wire logic                  power_down,
    // Interrupt and wake-up requests
    output logic                       counter_a_irq,
    output logic                       counter_b_irq,
    output logic                       wake_up_req
);

    // Reset synchroniser
    logic rst_meta_r;                          // First reset stage
    logic rstn_sync;                           // Released reset used everywhere

    // Prescaler
    logic [1:0] prescale_r;                    // Divide-by-four phase
    logic       tick;                          // Internal count clock pulse

    // Synchronised pin edges
    logic a_rise;                              // Counter A pin rising
    logic a_fall;                              // Counter A pin falling
    logic b_rise;                              // Counter B pin rising
    logic b_fall;                              // Counter B pin falling

    // Counter A state
    logic [7:0]              count_a_r;        // Counting register
    logic [7:0]              preload_a_r;      // Preload register
    logic [1:0]              mode_a_r;         // Mode pair
    logic                    run_a_r;          // Run bit
    logic                    edge_a_r;         // Edge select
    dtc_pkg::dtc_pwm_state_t pwm_a_r;          // Pulse width sequence
    dtc_pkg::dtc_pwm_state_t pwm_a_nxt;

    // Counter B state
    logic [15:0]             count_b_r;        // Counting register
    logic [15:0]             preload_b_r;      // Preload register
    logic [7:0]              low_buf_r;        // Low byte holding buffer
    logic [1:0]              mode_b_r;         // Mode pair
    logic                    run_b_r;          // Run bit
    logic                    edge_b_r;         // Edge select
    dtc_pkg::dtc_pwm_state_t pwm_b_r;          // Pulse width sequence
    dtc_pkg::dtc_pwm_state_t pwm_b_nxt;

    // Interrupt control
    logic ien_a_r;                             // Counter A interrupt enable
    logic ien_b_r;                             // Counter B interrupt enable
    logic flag_a_r;                            // Counter A request flag
    logic flag_b_r;                            // Counter B request flag

    // Decoded strobes
    logic wr_a_value;
    logic wr_a_ctrl;
    logic wr_b_low;
    logic wr_b_high;
    logic wr_b_ctrl;
    logic wr_interrupt_control_register;
    logic rd_b_high;

    // Count pulses, overflows and pulse ends
    logic inc_a;
    logic inc_b;
    logic ovf_a;
    logic ovf_b;
    logic pwm_stop_a;
    logic pwm_stop_b;

    // Assert at once, release through two flops
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_meta_r <= 1'b0;
            rstn_sync  <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rstn_sync  <= rst_meta_r;
        end
    end

    // Free-running divide by four
    always_ff @(posedge clock or negedge rstn_sync) begin
        if (!rstn_sync) begin
            prescale_r <= 2'h0;
        end else begin
            prescale_r <= prescale_r + 2'h1;
        end
    end

    assign tick = (prescale_r == dtc_pkg::PRESCALE_LAST);

    // Pin edge detectors; the pins are asynchronous to the clock
    dtc_pin_edge u_edge_a (
        .clock     (clock),
        .rstn_sync (rstn_sync),
        .pin       (counter_a_value_or_input_pin),
        .rise      (a_rise),
        .fall      (a_fall)
    );

    dtc_pin_edge u_edge_b (
        .clock     (clock),
        .rstn_sync (rstn_sync),
        .pin       (counter_b_input_pin),
        .rise      (b_rise),
        .fall      (b_fall)
    );

    // Address decode
    assign wr_a_value = bus_req.wr & (bus_req.addr == dtc_pkg::OFS_A_VALUE);
    assign wr_a_ctrl  = bus_req.wr & (bus_req.addr == dtc_pkg::OFS_A_CONTROL);
    assign wr_b_low   = bus_req.wr & (bus_req.addr == dtc_pkg::OFS_B_LOW);
    assign wr_b_high  = bus_req.wr & (bus_req.addr == dtc_pkg::OFS_B_HIGH);
    assign wr_b_ctrl  = bus_req.wr & (bus_req.addr == dtc_pkg::OFS_B_CONTROL);
    assign wr_interrupt_control_register    = bus_req.wr & (bus_req.addr == dtc_pkg::OFS_INT_CTRL);
    assign rd_b_high  = bus_req.rd & (bus_req.addr == dtc_pkg::OFS_B_HIGH);

    // Count pulse selection per mode; unused pattern gives no pulse
    assign inc_a = dtc_pkg::dtc_count_pulse(mode_a_r, run_a_r, tick, a_rise, a_fall,
                                            edge_a_r, pwm_a_r == dtc_pkg::PWM_MEASURE,
                                            power_down);
    assign inc_b = dtc_pkg::dtc_count_pulse(mode_b_r, run_b_r, tick, b_rise, b_fall,
                                            edge_b_r, pwm_b_r == dtc_pkg::PWM_MEASURE,
                                            power_down);

    // Overflow is a pulse arriving at the full count
    assign ovf_a = inc_a & (count_a_r == dtc_pkg::A_FULL);
    assign ovf_b = inc_b & (count_b_r == dtc_pkg::B_FULL);

    // Pulse width sequence; the count pulse masks the tick in power-down, so the
    // timed modes only advance on the internal tick while awake
    assign pwm_a_nxt = dtc_pkg::dtc_pwm_next(pwm_a_r, mode_a_r, run_a_r,
                                             a_rise, a_fall, edge_a_r);
    assign pwm_b_nxt = dtc_pkg::dtc_pwm_next(pwm_b_r, mode_b_r, run_b_r,
                                             b_rise, b_fall, edge_b_r);

    // The measured pulse ends when the pin returns to its level
    assign pwm_stop_a = (pwm_a_r == dtc_pkg::PWM_MEASURE) & (pwm_a_nxt == dtc_pkg::PWM_IDLE);
    assign pwm_stop_b = (pwm_b_r == dtc_pkg::PWM_MEASURE) & (pwm_b_nxt == dtc_pkg::PWM_IDLE);

    // Pulse width state registers
    always_ff @(posedge clock or negedge rstn_sync) begin
        if (!rstn_sync) begin
            pwm_a_r <= dtc_pkg::PWM_IDLE;
            pwm_b_r <= dtc_pkg::PWM_IDLE;
        end else begin
            pwm_a_r <= pwm_a_nxt;
            pwm_b_r <= pwm_b_nxt;
        end
    end

    // Counter A control register
    always_ff @(posedge clock or negedge rstn_sync) begin
        if (!rstn_sync) begin
            mode_a_r <= dtc_pkg::MODE_RESET;
            run_a_r  <= 1'b0;
            edge_a_r <= 1'b0;
        end else if (wr_a_ctrl) begin
            // Software write beats the automatic stop in the same cycle
            mode_a_r <= bus_req.wdata[dtc_pkg::MODE_HI:dtc_pkg::MODE_LO];
            run_a_r  <= bus_req.wdata[dtc_pkg::RUN_BIT];
            edge_a_r <= bus_req.wdata[dtc_pkg::EDGE_BIT];
        end else if (pwm_stop_a) begin
            run_a_r <= 1'b0;
        end
    end

    // Counter B control register
    always_ff @(posedge clock or negedge rstn_sync) begin
        if (!rstn_sync) begin
            mode_b_r <= dtc_pkg::MODE_RESET;
            run_b_r  <= 1'b0;
            edge_b_r <= 1'b0;
        end else if (wr_b_ctrl) begin
            mode_b_r <= bus_req.wdata[dtc_pkg::MODE_HI:dtc_pkg::MODE_LO];
            run_b_r  <= bus_req.wdata[dtc_pkg::RUN_BIT];
            edge_b_r <= bus_req.wdata[dtc_pkg::EDGE_BIT];
        end else if (pwm_stop_b) begin
            run_b_r <= 1'b0;
        end
    end

    // Counter A preload; given a defined reset although software
    // must still load it before use
    always_ff @(posedge clock or negedge rstn_sync) begin
        if (!rstn_sync) begin
            preload_a_r <= dtc_pkg::A_RESET;
        end else if (wr_a_value) begin
            preload_a_r <= bus_req.wdata;
        end
    end

    // Counter A counting register
    always_ff @(posedge clock or negedge rstn_sync) begin
        if (!rstn_sync) begin
            count_a_r <= dtc_pkg::A_RESET;
        end else if (wr_a_value && !run_a_r) begin
            count_a_r <= bus_req.wdata;
        end else if (ovf_a) begin
            count_a_r <= preload_a_r;
        end else if (inc_a) begin
            count_a_r <= count_a_r + 8'h01;
        end
    end

    // Low byte holding buffer, shared by writes and reads; the
    // byte order of software accesses keeps the two uses apart
    always_ff @(posedge clock or negedge rstn_sync) begin
        if (!rstn_sync) begin
            low_buf_r <= dtc_pkg::A_RESET;
        end else if (wr_b_low) begin
            low_buf_r <= bus_req.wdata;
        end else if (rd_b_high) begin
            low_buf_r <= count_b_r[7:0];
        end
    end

    // Counter B preload, loaded whole by the high byte write
    always_ff @(posedge clock or negedge rstn_sync) begin
        if (!rstn_sync) begin
            preload_b_r <= dtc_pkg::B_RESET;
        end else if (wr_b_high) begin
            preload_b_r <= {bus_req.wdata, low_buf_r};
        end
    end

    // Counter B counting register; a low byte write never touches it
    always_ff @(posedge clock or negedge rstn_sync) begin
        if (!rstn_sync) begin
            count_b_r <= dtc_pkg::B_RESET;
        end else if (wr_b_high && !run_b_r) begin
            count_b_r <= {bus_req.wdata, low_buf_r};
        end else if (ovf_b) begin
            count_b_r <= preload_b_r;
        end else if (inc_b) begin
            count_b_r <= count_b_r + 16'h0001;
        end
    end

    // Interrupt enables
    always_ff @(posedge clock or negedge rstn_sync) begin
        if (!rstn_sync) begin
            ien_a_r <= 1'b0;
            ien_b_r <= 1'b0;
        end else if (wr_interrupt_control_register) begin
            ien_a_r <= bus_req.wdata[dtc_pkg::IEN_A];
            ien_b_r <= bus_req.wdata[dtc_pkg::IEN_B];
        end
    end

    // Request flags; an overflow in the write cycle wins over a clear,
    // and software may also set a flag; the wake-up path ignores the flags
    always_ff @(posedge clock or negedge rstn_sync) begin
        if (!rstn_sync) begin
            flag_a_r <= 1'b0;
            flag_b_r <= 1'b0;
        end else begin
            if (ovf_a) begin
                flag_a_r <= 1'b1;
            end else if (wr_interrupt_control_register) begin
                flag_a_r <= bus_req.wdata[dtc_pkg::IFLG_A];
            end
            if (ovf_b) begin
                flag_b_r <= 1'b1;
            end else if (wr_interrupt_control_register) begin
                flag_b_r <= bus_req.wdata[dtc_pkg::IFLG_B];
            end
        end
    end

    // Delivered interrupts are gated by the enables
    always_ff @(posedge clock or negedge rstn_sync) begin
        if (!rstn_sync) begin
            counter_a_irq <= 1'b0;
            counter_b_irq <= 1'b0;
        end else begin
            counter_a_irq <= flag_a_r & ien_a_r;
            counter_b_irq <= flag_b_r & ien_b_r;
        end
    end

    // Wake-up on an overflow in power-down, enable or not; only event
    // mode can get here since the timed modes hold still then
    always_ff @(posedge clock or negedge rstn_sync) begin
        if (!rstn_sync) begin
            wake_up_req <= 1'b0;
        end else begin
            wake_up_req <= power_down & (ovf_a | ovf_b);
        end
    end

    // Read data, valid in the cycle after the strobe only
    always_ff @(posedge clock or negedge rstn_sync) begin
        if (!rstn_sync) begin
            bus_rdata <= dtc_pkg::RDATA_ZERO;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                dtc_pkg::OFS_A_VALUE:   bus_rdata <= count_a_r;
                dtc_pkg::OFS_A_CONTROL: bus_rdata <= {mode_a_r, 1'b0, run_a_r, edge_a_r, 3'h0};
                dtc_pkg::OFS_B_LOW:     bus_rdata <= low_buf_r;
                dtc_pkg::OFS_B_HIGH:    bus_rdata <= count_b_r[15:8];
                dtc_pkg::OFS_B_CONTROL: bus_rdata <= {mode_b_r, 1'b0, run_b_r, edge_b_r, 3'h0};
                dtc_pkg::OFS_INT_CTRL:  bus_rdata <= {2'h0, flag_b_r, flag_a_r,
                                                      2'h0, ien_b_r, ien_a_r};
                default:                bus_rdata <= dtc_pkg::RDATA_ZERO;
            endcase
        end else begin
            bus_rdata <= dtc_pkg::RDATA_ZERO;
        end
    end

endmodule : dtc_top

// File: verif/dtc_top_asserts.sv
`timescale 1ns/100ps

module dtc_top_asserts (
    // Clock and reset
    input wire logic                  clock,
    input wire logic                  rstn,
    // Register port
    input wire dtc_pkg::dtc_bus_req_t bus_req,
    input wire logic [7:0]            bus_rdata,
    // Pins and power state
    input wire logic                  counter_a_value_or_input_pin,
    input wire logic                  counter_b_input_pin,
    input wire logic                  power_down,
    // Requests
    input wire logic                  counter_a_irq,
    input wire logic                  counter_b_irq,
    input wire logic                  wake_up_req
);
    // Mirrors of what software last wrote
    logic       en_a_r, en_b_r, run_b_r, frz_r, known_r;
    logic [1:0] mode_a_r, mode_b_r;
    logic [7:0] buf_r, lo_r, hi_r;
    // Decoded strobes
    wire logic [7:0] ad    = bus_req.addr;
    wire logic       wr    = bus_req.wr;
    wire logic       rd_ia = bus_req.rd && ad == dtc_pkg::OFS_INT_CTRL;
    wire logic       rd_ac = bus_req.rd && ad == dtc_pkg::OFS_A_CONTROL;
    wire logic       rd_bc = bus_req.rd && ad == dtc_pkg::OFS_B_CONTROL;
    wire logic       rd_bl = bus_req.rd && ad == dtc_pkg::OFS_B_LOW;
    wire logic       rd_bh = bus_req.rd && ad == dtc_pkg::OFS_B_HIGH;

    // Mirror logic; a load while B is stopped stays exact, so only then is it trusted
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            {en_a_r, en_b_r, run_b_r, frz_r, known_r} <= 5'h00;
            {mode_a_r, mode_b_r} <= 4'h0;
            {buf_r, lo_r, hi_r} <= 24'h000000;
        end else begin
            if (wr && ad == dtc_pkg::OFS_INT_CTRL) begin
                en_a_r <= bus_req.wdata[dtc_pkg::IEN_A];
                en_b_r <= bus_req.wdata[dtc_pkg::IEN_B];
            end
            if (wr && ad == dtc_pkg::OFS_A_CONTROL) mode_a_r <= bus_req.wdata[7:6];
            if (wr && ad == dtc_pkg::OFS_B_CONTROL) begin
                mode_b_r <= bus_req.wdata[7:6];
                run_b_r  <= bus_req.wdata[dtc_pkg::RUN_BIT];
                if (bus_req.wdata[dtc_pkg::RUN_BIT]) frz_r <= 1'b0;
            end
            if (wr && ad == dtc_pkg::OFS_B_LOW) begin
                buf_r   <= bus_req.wdata;
                known_r <= 1'b1;
            end
            if (wr && ad == dtc_pkg::OFS_B_HIGH) begin
                hi_r  <= bus_req.wdata;
                lo_r  <= buf_r;
                // Only a known buffer makes the loaded low byte known
                frz_r <= !run_b_r && known_r;
            end
            if (rd_bh) begin
                buf_r   <= lo_r;
                known_r <= frz_r;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_irq_a_gate: assert property (counter_a_irq |-> $past(en_a_r))
        else $error("irq a without enable");
    a_irq_b_gate: assert property (counter_b_irq |-> $past(en_b_r))
        else $error("irq b without enable");
    a_wake_in_pd: assert property (wake_up_req |-> $past(power_down))
        else $error("wake outside power-down");
    a_interrupt_control_register_rd_back: assert property ($past(rd_ia) |-> bus_rdata[1:0] == $past({en_b_r, en_a_r})
        && bus_rdata[7:6] == 2'h0 && bus_rdata[3:2] == 2'h0) else $error("interrupt_control_register readback");
    a_mode_a_rd: assert property (rd_ac |=> bus_rdata[7:6] == $past(mode_a_r) && !bus_rdata[5])
        else $error("mode a readback");
    a_mode_b_rd: assert property ($past(rd_bc) |-> bus_rdata[7:6] == $past(mode_b_r)
        && bus_rdata[2:0] == 3'h0) else $error("mode b readback");
    a_low_rd_buf: assert property ($past(rd_bl) && $past(known_r) |-> bus_rdata == $past(buf_r))
        else $error("low byte not from buffer");
    a_high_rd_frz: assert property (rd_bh && frz_r |=> bus_rdata == $past(hi_r))
        else $error("high byte load lost");
endmodule : dtc_top_asserts

bind dtc_top dtc_top_asserts u_asserts (.clock(clock), .rstn(rstn), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .counter_a_value_or_input_pin(counter_a_value_or_input_pin),
    .counter_b_input_pin(counter_b_input_pin), .power_down(power_down),
    .counter_a_irq(counter_a_irq), .counter_b_irq(counter_b_irq), .wake_up_req(wake_up_req));

// File: verif/dtc_pin_src.sv
`timescale 1ns/100ps

module dtc_pin_src (
    // Clock
    input wire logic       clock,
    // Command: toggle the pin n times, half cycles apart
    input wire logic       go,
    input wire logic [7:0] n,
    input wire logic [7:0] half,
    // Pin and status
    output logic           pin,
    output logic           busy
);
    logic       pin_r  = 1'b0;  // Pin level, held between bursts
    logic       busy_r = 1'b0;  // Burst in progress
    logic [7:0] left_r = 8'h00; // Toggles still to make
    logic [7:0] cnt_r  = 8'h00; // Cycles to the next toggle

    assign pin  = pin_r;
    assign busy = busy_r;

    // Burst generator; slow spacing keeps each level past the pin synchroniser
    always_ff @(posedge clock) begin
        if (go && !busy_r) begin
            left_r <= n;
            cnt_r  <= half;
            busy_r <= n != 8'h00;
        end else if (busy_r) begin
            if (cnt_r <= 8'h01) begin
                pin_r  <= ~pin_r;
                cnt_r  <= half;
                left_r <= left_r - 8'h01;
                busy_r <= left_r > 8'h01;
            end else begin
                cnt_r <= cnt_r - 8'h01;
            end
        end
    end
endmodule : dtc_pin_src

// File: verif/dtc_top_tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end

module dtc_top_tb;
    logic                  clock = 1'b0;           // 40 MHz system clock
    logic                  rstn, power_down, woke; // Reset, power state, wake seen
    logic                  go_a, go_b, pin_a, pin_b, busy_a, busy_b;
    logic                  irq_a, irq_b, wake;
    logic [7:0]            bus_rdata, src_n, src_h, d;
    dtc_pkg::dtc_bus_req_t bus_req;
    int                    err_count, check_count;

    always #12.5 clock = ~clock;

    dtc_top dut (.clock(clock), .rstn(rstn), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .counter_a_value_or_input_pin(pin_a), .counter_b_input_pin(pin_b),
        .power_down(power_down), .counter_a_irq(irq_a), .counter_b_irq(irq_b),
        .wake_up_req(wake));
    dtc_pin_src u_src_a (.clock(clock), .go(go_a), .n(src_n), .half(src_h), .pin(pin_a),
        .busy(busy_a));
    dtc_pin_src u_src_b (.clock(clock), .go(go_b), .n(src_n), .half(src_h), .pin(pin_b),
        .busy(busy_b));

    // Wake is a one-cycle pulse, so latch it
    always @(posedge clock) if (wake === 1'b1) woke <= 1'b1;

    // One-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock) bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clock) bus_req <= '0;
    endtask : wr

    // One-cycle register read; data stand only in the following cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clock) bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock) bus_req <= '0;
        #1 v = bus_rdata;
    endtask : rd

    // Burst of pin toggles, then margin for the synchroniser
    task automatic pulse(input logic b, input logic [7:0] n, input logic [7:0] h);
        @(posedge clock) begin
            src_n <= n;
            src_h <= h;
            go_a  <= !b;
            go_b  <= b;
        end
        @(posedge clock) {go_a, go_b} <= 2'b00;
        #1;
        for (int i = 0; i < 4000 && (busy_a | busy_b) !== 1'b0; i++) @(posedge clock);
        // A burst that never ends counts as a mismatch
        if ((busy_a | busy_b) !== 1'b0) err_count++;
        repeat (8) @(posedge clock);
    endtask : pulse

    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    // Watchdog at 10000 cycles, well past the roughly 1400 cycles the tests need
    initial begin
        #250000;
        err_count++;
        report_and_stop();
    end

    initial begin
        {rstn, power_down, woke, go_a, go_b, src_n, src_h} = '0;
        {err_count, check_count} = '0;
        bus_req = '0;
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        rd(dtc_pkg::OFS_A_CONTROL, d); `CHK(d, 8'h00)
        rd(8'h07, d); `CHK(d, 8'h00)
        // Stopped pattern holds a loaded value
        wr(dtc_pkg::OFS_A_VALUE, 8'h5a);
        wr(dtc_pkg::OFS_A_CONTROL, 8'h10);
        repeat (40) @(posedge clock);
        rd(dtc_pkg::OFS_A_VALUE, d); `CHK(d, 8'h5a)
        // Timer mode: late preload reaches the count only at overflow
        wr(dtc_pkg::OFS_A_CONTROL, 8'h00);
        wr(dtc_pkg::OFS_A_VALUE, 8'hfe);
        wr(dtc_pkg::OFS_INT_CTRL, 8'h01);
        wr(dtc_pkg::OFS_A_CONTROL, 8'h90);
        wr(dtc_pkg::OFS_A_VALUE, 8'h10);
        for (int i = 0; i < 40 && irq_a !== 1'b1; i++) @(posedge clock);
        `CHK(irq_a, 1'b1)
        rd(dtc_pkg::OFS_A_VALUE, d); `CHK(d & 8'hfe, 8'h10)
        rd(dtc_pkg::OFS_INT_CTRL, d); `CHK(d, 8'h11)
        // Disabled: write clears the flag, next overflow sets it again, no request
        wr(dtc_pkg::OFS_INT_CTRL, 8'h00);
        repeat (1100) @(posedge clock);
        `CHK(irq_a, 1'b0)
        rd(dtc_pkg::OFS_INT_CTRL, d); `CHK(d, 8'h10)
        wr(dtc_pkg::OFS_A_CONTROL, 8'h00);
        // Event mode B in power-down, rising edges
        wr(dtc_pkg::OFS_B_LOW, 8'hfd);
        wr(dtc_pkg::OFS_B_HIGH, 8'hff);
        wr(dtc_pkg::OFS_INT_CTRL, 8'h02);
        power_down <= 1'b1;
        wr(dtc_pkg::OFS_B_CONTROL, 8'h50);
        pulse(1'b1, 8'h05, 8'h06);
        `CHK(woke, 1'b1)
        `CHK(irq_b, 1'b1)
        power_down <= 1'b0;
        rd(dtc_pkg::OFS_B_HIGH, d); `CHK(d, 8'hff)
        rd(dtc_pkg::OFS_B_LOW, d); `CHK(d, 8'hfd)
        // Falling edges from a high pin: two counts, not one
        wr(dtc_pkg::OFS_B_CONTROL, 8'h58);
        pulse(1'b1, 8'h03, 8'h06);
        rd(dtc_pkg::OFS_B_HIGH, d); `CHK(d, 8'hff)
        rd(dtc_pkg::OFS_B_LOW, d); `CHK(d, 8'hff)
        // Low write alone leaves the count, high write moves it
        wr(dtc_pkg::OFS_B_CONTROL, 8'h00);
        rd(dtc_pkg::OFS_B_CONTROL, d); `CHK(d, 8'h00)
        wr(dtc_pkg::OFS_B_LOW, 8'h33);
        rd(dtc_pkg::OFS_B_HIGH, d); `CHK(d, 8'hff)
        rd(dtc_pkg::OFS_B_LOW, d); `CHK(d, 8'hff)
        // The high read above latched the live low byte, so load the buffer again
        wr(dtc_pkg::OFS_B_LOW, 8'h33);
        wr(dtc_pkg::OFS_B_HIGH, 8'h12);
        rd(dtc_pkg::OFS_B_HIGH, d); `CHK(d, 8'h12)
        rd(dtc_pkg::OFS_B_LOW, d); `CHK(d, 8'h33)
        // Pulse measurement on A: 40 cycles high is ten prescaled ticks
        wr(dtc_pkg::OFS_A_VALUE, 8'h00);
        wr(dtc_pkg::OFS_A_CONTROL, 8'hd8);
        pulse(1'b0, 8'h02, 8'h28);
        rd(dtc_pkg::OFS_A_CONTROL, d); `CHK(d, 8'hc8)
        rd(dtc_pkg::OFS_A_VALUE, d); `CHK(d >= 8'h09 && d <= 8'h0b, 1'b1)
        report_and_stop();
    end
endmodule : dtc_top_tb
